// ==== hw/sra_pkg.sv ====
// constants and types shared by the serial register access port
`default_nettype none
package sra_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned FIFO_W = 16;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [5:0] I2C_ADDR_HI = 6'h3B;
   localparam int unsigned RW_BIT = 7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
   localparam logic [3:0] I2C_RD_LAST = 4'h7;
   localparam logic SPI_CTL_FIRST = 1'b1;
   typedef enum logic [6:0] {
      I_IDLE = 7'h01,
      I_ADDR = 7'h02,
      I_AACK = 7'h04,
      I_WR = 7'h08,
      I_WACK = 7'h10,
      I_RD = 7'h20,
      I_RACK = 7'h40
   } sra_i2c_e;
endpackage
`default_nettype wire

// ==== hw/sra_top.sv ====
// serial register access port: two-wire and spi target with write fifo
`default_nettype none

module sra_fifo import sra_pkg::*; #(
   parameter int unsigned W = FIFO_W,
   parameter int unsigned D = FIFO_DEPTH
) (
   input wire logic clk_i,          // core clock
   input wire logic rst_b_i,        // async reset, low
   input wire logic in_valid_i,     // push request
   output logic in_ready_o,         // space left
   input wire logic [W-1:0] in_data_i, // pushed word
   output logic out_valid_o,        // word available
   input wire logic out_ready_i,    // sink takes word
   output logic [W-1:0] out_data_o  // head word
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;
   assign in_ready_o = cnt != D[AW:0];
   assign out_valid_o = cnt != '0;
   assign out_data_o = mem[rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always_comb begin
      next_wp = push ? AW'(wp + 1'b1) : wp;
      next_rp = pop ? AW'(rp + 1'b1) : rp;
      next_cnt = (AW+1)'(cnt + {AW'(0), push} - {AW'(0), pop});
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp] <= in_data_i;
      end
   end
   full_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cnt == D[AW:0] && !pop) |=> (cnt == D[AW:0] && !in_ready_o))
      else $error("fifo lost its full state");
endmodule // sra_fifo

module sra_top import sra_pkg::*; (
   input wire logic core_clk_i,     // core clock, 100 MHz
   input wire logic rst_b_i,        // power-on reset, low
   input wire logic sck_i,          // serial clock pin
   input wire logic csb_b_i,        // select pin, low
   input wire logic sdi_i,          // data pin level
   output logic sdi_o,              // data pin drive
   output logic sdi_oe_o,           // data pin enable
   input wire logic sdo_i,          // output pin level
   output logic sdo_o,              // output pin drive
   output logic sdo_oe_o,           // output pin enable
   input wire logic three_wire_enable_i, // three-wire setting
   output logic wr_valid_o,         // write word ready
   input wire logic wr_ready_i,     // write word taken
   output logic [ADDR_W-1:0] wr_addr_o, // write address
   output logic [BYTE_W-1:0] wr_data_o, // write data
   output logic rd_strobe_o,        // read request pulse
   output logic [ADDR_W-1:0] rd_addr_o, // read address
   input wire logic [BYTE_W-1:0] rd_data_i, // read data
   output logic spi_mode_o,         // 1: mode 11
   output logic i2c_active_o        // two-wire enabled
);
   // ---- link domain, clocked by the serial clock pin
   logic spi_arst_b;
   logic [2:0] bcnt, next_bcnt;
   logic [6:0] sh, next_sh, rq_addr, next_rq_addr, wa, next_wa;
   logic [7:0] wd, next_wd, byte_in, tx, next_tx;
   logic ctl_ph, next_ctl_ph, reading, next_reading, drv_on, next_drv_on;
   logic rd_tgl, next_rd_tgl, wr_tgl, next_wr_tgl, tw_m, tw, next_tw_m;
   logic [BYTE_W-1:0] rd_hold, next_rd_hold;

   // raising select clears the frame even with the clock stopped
   assign spi_arst_b = rst_b_i & ~csb_b_i;

   always_comb begin
      byte_in = {sh, sdi_i};
      next_sh = byte_in[6:0];
      next_bcnt = 3'(bcnt + 1'b1);
      next_ctl_ph = ctl_ph;
      next_reading = reading;
      next_rq_addr = rq_addr;
      next_rd_tgl = rd_tgl;
      next_wr_tgl = wr_tgl;
      next_wa = wa;
      next_wd = wd;
      next_tw_m = three_wire_enable_i;
      if (spi_arst_b && bcnt == BIT_LAST) begin
         if (reading) begin
            next_rq_addr = 7'(rq_addr + 1'b1);
            next_rd_tgl = ~rd_tgl;
         end else if (ctl_ph) begin
            next_rq_addr = byte_in[6:0];
            if (byte_in[RW_BIT]) begin
               next_reading = 1'b1;
               next_rd_tgl = ~rd_tgl;
            end else begin
               next_ctl_ph = 1'b0;
            end
         end else begin
            next_wa = rq_addr;
            next_wd = byte_in;
            next_wr_tgl = ~wr_tgl;
            next_ctl_ph = SPI_CTL_FIRST;
         end
      end
   end

   always_ff @(posedge sck_i or negedge spi_arst_b) begin
      if (!spi_arst_b) begin
         bcnt <= '0;
         sh <= '0;
         ctl_ph <= SPI_CTL_FIRST;
         reading <= 1'b0;
         tw_m <= 1'b0;
         tw <= 1'b0;
      end else begin
         bcnt <= next_bcnt;
         sh <= next_sh;
         ctl_ph <= next_ctl_ph;
         reading <= next_reading;
         tw_m <= next_tw_m;
         tw <= tw_m;
      end
   end

   // hand-off words outlive the frame so the core can still pick them up
   always_ff @(posedge sck_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rq_addr <= '0;
         rd_tgl <= 1'b0;
         wr_tgl <= 1'b0;
         wa <= '0;
         wd <= '0;
      end else begin
         rq_addr <= next_rq_addr;
         rd_tgl <= next_rd_tgl;
         wr_tgl <= next_wr_tgl;
         wa <= next_wa;
         wd <= next_wd;
      end
   end

   // rd_hold is refreshed about 4 core cycles after the request toggle,
   // well inside the half link period before this edge uses it
   always_comb begin
      next_tx = (bcnt == '0 && reading) ? rd_hold : {tx[6:0], 1'b0};
      // turn the pin round on the falling edge, so the host's last bit is not fought
      next_drv_on = reading;
   end

   always_ff @(negedge sck_i or negedge spi_arst_b) begin
      if (!spi_arst_b) begin
         tx <= '0;
         drv_on <= 1'b0;
      end else begin
         tx <= next_tx;
         drv_on <= next_drv_on;
      end
   end

   ctl_read_a: assert property (@(posedge sck_i) disable iff (!spi_arst_b)
      (ctl_ph && !reading && bcnt == BIT_LAST && sdi_i == 1'b0 && sh[6])
      |=> (reading && rd_tgl != $past(rd_tgl)))
      else $error("read control byte did not start a read");
   pair_write_a: assert property (@(posedge sck_i) disable iff (!spi_arst_b)
      (!ctl_ph && !reading && bcnt == BIT_LAST)
      |=> (wr_tgl != $past(wr_tgl) && wa == $past(rq_addr) && ctl_ph))
      else $error("spi data byte not handed over");

   // ---- core domain
   logic csb_m, csb_s, csb_q, scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
   logic ads_m, ads_s, wt_m, wt_s, wt_q, rt_m, rt_s, rt_q;
   sra_i2c_e st, next_st;
   logic [3:0] cnt, next_cnt;
   logic [7:0] ish, next_ish, reg_addr, next_reg_addr;
   logic [ADDR_W-1:0] rd_addr, next_rd_addr;
   logic i2c_off, next_i2c_off, spi_mode, next_spi_mode;
   logic rd_pend, next_rd_pend, phase_data, next_phase_data, nack, next_nack;
   logic i2c_en, start, stop, rise, fall, i2c_oe, i2c_push, spi_push;
   logic push_v, push_rdy;
   logic [FIFO_W-1:0] push_d;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {csb_m, csb_s, csb_q} <= 3'h7;
         {scl_m, scl_s, scl_q} <= 3'h7;
         {sda_m, sda_s, sda_q} <= 3'h7;
         {ads_m, ads_s} <= 2'h0;
         {wt_m, wt_s, wt_q} <= 3'h0;
         {rt_m, rt_s, rt_q} <= 3'h0;
      end else begin
         {csb_m, csb_s, csb_q} <= {csb_b_i, csb_m, csb_s};
         {scl_m, scl_s, scl_q} <= {sck_i, scl_m, scl_s};
         {sda_m, sda_s, sda_q} <= {sdi_i, sda_m, sda_s};
         {ads_m, ads_s} <= {sdo_i, ads_m};
         {wt_m, wt_s, wt_q} <= {wr_tgl, wt_m, wt_s};
         {rt_m, rt_s, rt_q} <= {rd_tgl, rt_m, rt_s};
      end
   end

   assign i2c_en = ~i2c_off & csb_s;
   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop = scl_s & scl_q & ~sda_q & sda_s;
   assign rise = scl_s & ~scl_q;
   assign fall = ~scl_s & scl_q;
   assign spi_push = wt_s ^ wt_q;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_ish = ish;
      next_reg_addr = reg_addr;
      next_phase_data = phase_data;
      next_nack = nack;
      next_rd_addr = rd_addr;
      next_rd_pend = 1'b0;
      next_rd_hold = rd_pend ? rd_data_i : rd_hold;
      next_i2c_off = i2c_off | ~csb_s;
      next_spi_mode = (csb_q & ~csb_s) ? scl_s : spi_mode;
      i2c_push = 1'b0;
      if (rt_s ^ rt_q) begin
         next_rd_addr = {1'b0, rq_addr};
         next_rd_pend = 1'b1;
      end
      if (!i2c_en || stop) begin
         next_st = I_IDLE;
      end else if (start) begin
         next_st = I_ADDR;
         next_cnt = '0;
      end else begin
         case (st)
            I_ADDR, I_WR: begin
               if (rise) begin
                  next_ish = {ish[6:0], sda_s};
                  next_cnt = 4'(cnt + 1'b1);
               end
               if (fall && cnt == I2C_BYTE_BITS) begin
                  if (st == I_ADDR) begin
                     next_st = (ish[7:1] == {I2C_ADDR_HI, ads_s}) ? I_AACK : I_IDLE;
                  end else if (!phase_data) begin
                     next_reg_addr = ish;
                     next_phase_data = 1'b1;
                     next_st = I_WACK;
                  end else if (push_rdy && !spi_push) begin
                     i2c_push = 1'b1;
                     next_phase_data = 1'b0;
                     next_st = I_WACK;
                  end else begin
                     // full fifo: byte refused with a nack, no stretching
                     next_st = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               if (fall) begin
                  next_cnt = '0;
                  next_phase_data = 1'b0;
                  if (ish[0]) begin
                     next_st = I_RD;
                     next_rd_addr = reg_addr;
                     next_rd_pend = 1'b1;
                  end else begin
                     next_st = I_WR;
                  end
               end
            end
            I_WACK: begin
               if (fall) begin
                  next_cnt = '0;
                  next_st = I_WR;
               end
            end
            I_RD: begin
               if (fall) begin
                  next_cnt = 4'(cnt + 1'b1);
                  next_st = (cnt == I2C_RD_LAST) ? I_RACK : I_RD;
               end
            end
            I_RACK: begin
               if (rise) begin
                  next_nack = sda_s;
               end
               if (fall) begin
                  if (nack) begin
                     next_st = I_IDLE;
                  end else begin
                     next_reg_addr = 8'(reg_addr + 1'b1);
                     next_rd_addr = 8'(reg_addr + 1'b1);
                     next_rd_pend = 1'b1;
                     next_cnt = '0;
                     next_st = I_RD;
                  end
               end
            end
            I_IDLE: begin
            end
            default: begin
               next_st = I_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= I_IDLE;
         cnt <= '0;
         ish <= '0;
         reg_addr <= '0;
         phase_data <= 1'b0;
         nack <= 1'b0;
         rd_addr <= '0;
         rd_pend <= 1'b0;
         rd_hold <= '0;
         i2c_off <= 1'b0;
         spi_mode <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         ish <= next_ish;
         reg_addr <= next_reg_addr;
         phase_data <= next_phase_data;
         nack <= next_nack;
         rd_addr <= next_rd_addr;
         rd_pend <= next_rd_pend;
         rd_hold <= next_rd_hold;
         i2c_off <= next_i2c_off;
         spi_mode <= next_spi_mode;
      end
   end

   // an spi write arriving with the fifo full is dropped
   assign push_v = spi_push | i2c_push;
   assign push_d = spi_push ? {1'b0, wa, wd} : {reg_addr, ish};

   sra_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_wr_fifo (
      .clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push_v),
      .in_ready_o(push_rdy),
      .in_data_i(push_d),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o({wr_addr_o, wr_data_o})
   );

   assign i2c_oe = (st == I_AACK) | (st == I_WACK)
      | ((st == I_RD) & ~rd_hold[3'h7 - cnt[2:0]]);
   assign sdi_o = tx[7] & ~i2c_oe;
   assign sdi_oe_o = i2c_oe | (drv_on & tw);
   assign sdo_o = tx[7];
   assign sdo_oe_o = drv_on & ~tw;
   assign rd_strobe_o = rd_pend;
   assign rd_addr_o = rd_addr;
   assign spi_mode_o = spi_mode;
   assign i2c_active_o = i2c_en;

   lock_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (!csb_s) |=> (i2c_off && !i2c_active_o) [*3])
      else $error("two-wire port not locked after select low");
   mode_pick_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (csb_q && !csb_s) |=> (spi_mode_o == $past(scl_s)))
      else $error("spi mode not taken from clock level");
   addr_match_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(st == I_AACK) |-> ($past(ish[7:1]) == {I2C_ADDR_HI, $past(ads_s)}))
      else $error("acknowledged a foreign address");
   ack_drive_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st == I_AACK || st == I_WACK) |-> (sdi_oe_o && !sdi_o))
      else $error("acknowledge not driven low");
   rd_incr_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (i2c_en && !start && !stop && st == I_RACK && fall && !nack)
      |=> (reg_addr == $past(reg_addr) + 8'h01 && rd_strobe_o))
      else $error("read address not advanced");
   nack_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st == I_RACK && fall && nack) |=> (st == I_IDLE) [*2])
      else $error("read went on after host nack");
   sel_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st != I_IDLE) |-> (csb_s && !i2c_off))
      else $error("two-wire busy while spi selected");
endmodule // sra_top
`default_nettype wire

// ==== test/sra_host.sv ====
// host model: drives clock, select and data pins of both links
`default_nettype none
module sra_host (
   output logic sck_o,     // serial clock
   output logic csb_b_o,   // select, low
   output logic sdi_o,     // data drive value
   output logic sdi_oe_o,  // data drive enable
   input wire logic sdi_i, // resolved data wire
   input wire logic sdo_i  // resolved output pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_o = 1'b1;
      csb_b_o = 1'b1;
      sdi_o = 1'b1;
      sdi_oe_o = 1'b0;
   end
   // also serves as repeated start from clock low
   task automatic tw_start();
      #3; // keeps link edges off the core clock edges
      sdi_oe_o = 1'b0;
      #40;
      sck_o = 1'b1; // clock is driven, never waited on
      #40;
      sdi_o = 1'b0;
      sdi_oe_o = 1'b1;
      #40;
      sck_o = 1'b0;
   endtask
   task automatic tw_bit(input logic b, output logic q);
      #40;
      sdi_o = 1'b0;
      sdi_oe_o = ~b; // open drain: only pulls low
      #40;
      sck_o = 1'b1;
      #40;
      q = sdi_i;
      #40;
      sck_o = 1'b0;
   endtask
   task automatic tw_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         tw_bit(d[i], r);
      end
      tw_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic tw_read(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         tw_bit(1'b1, d[i]);
      end
      tw_bit(last, r); // released bit is the closing nack
   endtask
   task automatic tw_stop();
      #40;
      sdi_o = 1'b0;
      sdi_oe_o = 1'b1;
      #40;
      sck_o = 1'b1;
      #40;
      sdi_oe_o = 1'b0; // data rises while clock high
      #80;
   endtask
   task automatic spi_begin(input logic mode);
      #3; // keeps link edges off the core clock edges
      sck_o = mode; // clock settles before select moves
      #80;
      csb_b_o = 1'b0;
      #80;
   endtask
   task automatic spi_byte(input logic [7:0] d, input logic drv, input logic three,
                           output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         sck_o = 1'b0;
         sdi_o = d[i]; // drive after the falling edge
         sdi_oe_o = drv;
         #80;
         sck_o = 1'b1;
         q[i] = three ? sdi_i : sdo_i;
         #80;
      end
   endtask
   task automatic spi_end(input logic mode);
      sck_o = mode;
      #80;
      csb_b_o = 1'b1;
      sdi_oe_o = 1'b0;
      #80;
      sck_o = 1'b1;
      #80;
   endtask
endmodule // sra_host
`default_nettype wire

// ==== test/sra_top_tb_top.sv ====
// testbench: host model on both links, checks fifo words, read data and pin enables
`default_nettype none
module sra_top_tb_top import sra_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic sck, csb_b, h_sdi, h_oe, sdi_w, sdo_w, sdi_drv, sdi_oe, sdo_drv, sdo_oe;
   logic wr_valid, rd_strobe, spi_mode, i2c_active, ack;
   logic sdi_last = 1'b1;
   logic tw_wiring = 1'b1;
   logic addr_sel = 1'b0;
   logic three_wire_enable = 1'b0;
   logic wr_ready = 1'b0;
   logic [ADDR_W-1:0] wr_addr, rd_addr, p, strobed;
   logic [BYTE_W-1:0] wr_data, rd_data, a, d, q;
   logic [BYTE_W-1:0] mem [256];
   logic [15:0] expq [$];
   logic [31:0] seed = 32'hE7AD;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int strobes = 0;
   always #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) sdi_last <= sdi_w;
   // counts read requests and keeps the address of the latest one
   always @(posedge core_clk_i) begin
      if (rd_strobe === 1'b1) begin
         strobes++;
         strobed = rd_addr;
      end
   end
   // released line: pull-up when wired for two-wire, else a changing level
   assign sdi_w = sdi_oe ? sdi_drv : (h_oe ? h_sdi : (tw_wiring ? 1'b1 : ~sdi_last));
   assign sdo_w = sdo_oe ? sdo_drv : addr_sel;
   assign rd_data = mem[rd_addr];
   sra_top dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .csb_b_i(csb_b),
      .sdi_i(sdi_w), .sdi_o(sdi_drv), .sdi_oe_o(sdi_oe), .sdo_i(sdo_w), .sdo_o(sdo_drv),
      .sdo_oe_o(sdo_oe), .three_wire_enable_i(three_wire_enable), .wr_valid_o(wr_valid),
      .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .rd_strobe_o(rd_strobe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
      .spi_mode_o(spi_mode), .i2c_active_o(i2c_active));
   sra_host host_u (.sck_o(sck), .csb_b_o(csb_b), .sdi_o(h_sdi), .sdi_oe_o(h_oe),
      .sdi_i(sdi_w), .sdo_i(sdo_w));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rnd();
      repeat (8) seed = lfsr(seed);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] tw_addr(input logic rw);
      return {I2C_ADDR_HI, addr_sel, rw};
   endfunction
   function automatic logic [7:0] ctl(input logic rw, input logic [7:0] ad);
      return {rw, ad[6:0]};
   endfunction
   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_flag(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic drain();
      logic [15:0] e;
      int k;
      @(posedge core_clk_i) wr_ready <= 1'b1;
      while (expq.size() > 0) begin
         e = expq.pop_front();
         k = 0;
         do begin
            @(negedge core_clk_i);
            k++;
         end while (wr_valid !== 1'b1 && k < 200);
         chk_word("fifo word", e, {wr_addr, wr_data});
         @(posedge core_clk_i);
      end
      wr_ready <= 1'b0;
      @(negedge core_clk_i);
      chk_flag("fifo empty", 1'b0, wr_valid);
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = rnd();
      end
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk_flag("two-wire on", 1'b1, i2c_active);
      chk_flag("fifo valid", 1'b0, wr_valid);
      chk_flag("sdo enable", 1'b0, sdo_oe);
      @(posedge core_clk_i) rst_b_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      // sink stalled: eight pairs fill the fifo, the ninth data byte is refused
      host_u.tw_start();
      host_u.tw_byte(tw_addr(1'b0), ack);
      chk_flag("addr ack", 1'b1, ack);
      for (int i = 0; i < 9; i++) begin
         a = rnd();
         d = rnd();
         host_u.tw_byte(a, ack);
         chk_flag("reg ack", 1'b1, ack);
         host_u.tw_byte(d, ack);
         chk_flag("data ack", i < 8, ack);
         if (i < 8) expq.push_back({a, d});
      end
      host_u.tw_stop();
      drain();
      host_u.tw_start();
      host_u.tw_byte({I2C_ADDR_HI, 1'b1, 1'b0}, ack);
      chk_flag("other addr ack", 1'b0, ack);
      host_u.tw_stop();
      @(posedge core_clk_i) addr_sel <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      p = rnd();
      strobes = 0;
      host_u.tw_start();
      host_u.tw_byte(tw_addr(1'b0), ack);
      host_u.tw_byte(p, ack);
      host_u.tw_start();
      host_u.tw_byte(tw_addr(1'b1), ack);
      chk_flag("read addr ack", 1'b1, ack);
      for (int i = 0; i < 3; i++) begin
         host_u.tw_read(i == 2, d);
         chk_byte("tw read", mem[8'(p + i)], d);
      end
      host_u.tw_stop();
      // two host target_acknowledge: one request per byte, none after the nack
      chk_byte("tw strobes", 8'h03, 8'(strobes));
      chk_byte("tw last addr", 8'(p + 2), strobed);
      for (int m = 0; m < 2; m++) begin
         host_u.spi_begin(m[0]);
         // floating data line only once the two-wire port is locked
         tw_wiring = 1'b0;
         chk_flag("two-wire off", 1'b0, i2c_active);
         for (int i = 0; i < 2; i++) begin
            a = rnd();
            d = rnd();
            host_u.spi_byte(ctl(1'b0, a), 1'b1, 1'b0, q);
            host_u.spi_byte(d, 1'b1, 1'b0, q);
            expq.push_back({ctl(1'b0, a), d});
         end
         host_u.spi_end(m[0]);
         chk_flag("spi mode", m[0], spi_mode);
         drain();
      end
      for (int t = 0; t < 2; t++) begin
         @(posedge core_clk_i) three_wire_enable <= t[0];
         p = rnd() & 8'h7C;
         strobes = 0;
         host_u.spi_begin(t[0]);
         host_u.spi_byte(ctl(1'b1, p), 1'b1, t[0], q);
         for (int i = 0; i < 3; i++) begin
            host_u.spi_byte(rnd(), 1'b0, t[0], q);
            chk_byte("spi read", mem[8'(p + i)], q);
            if (i == 0) begin
               chk_flag("sdo enable", ~t[0], sdo_oe);
               chk_flag("sdi enable", t[0], sdi_oe);
            end
         end
         host_u.spi_end(t[0]);
         // control byte plus one prefetch after each of the three data bytes
         chk_byte("spi strobes", 8'h04, 8'(strobes));
         chk_byte("spi last addr", 8'(p + 3), strobed);
      end
      @(posedge core_clk_i) three_wire_enable <= 1'b0;
      tw_wiring = 1'b1;
      host_u.tw_start();
      host_u.tw_byte(tw_addr(1'b0), ack);
      chk_flag("locked ack", 1'b0, ack);
      host_u.tw_stop();
      chk_flag("two-wire locked", 1'b0, i2c_active);
      conclude();
   end
endmodule // sra_top_tb_top
`default_nettype wire
